// *** rtl/cmc_cluster.sv ***
// Per-core memory cluster: L2 stream prefetch, store
// forwarding, load disambiguation and the miss lookup order.
// Assumes the load/store pipeline and shared L2 answer on
// ref_clk and keep the handshakes documented at the ports.
`timescale 1ns/1ps
`default_nettype none
module cmc_cluster #(
  parameter logic CORE_ID = 1'h0,
  parameter int UP_N = cmc_pkg::PF_UP_N,
  parameter int DN_N = cmc_pkg::PF_DN_N,
  parameter int SB_N = cmc_pkg::SB_N,
  parameter int LQ_N = cmc_pkg::LQ_N,
  parameter int PRED_N = cmc_pkg::PRED_N,
  parameter int BUS_RATIO = cmc_pkg::BUS_RATIO
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // Data cache requests seen by the L2
  input wire logic dreq_valid,
  input wire logic dreq_core,
  input wire logic [31:0] dreq_addr,
  input wire logic bus_busy,
  input wire logic [3:0] outst_cnt,
  output logic [1:0] pf_valid,
  output logic [31:0] pf_addr0,
  output logic [31:0] pf_addr1,
  // Store buffer updates
  input wire logic st_alloc,
  input wire logic st_retire,
  input wire logic st_addr_valid,
  input wire logic [4:0] st_idx,
  input wire logic [31:0] st_addr,
  input wire logic [2:0] st_size,
  input wire logic st_data_valid,
  input wire logic [4:0] st_data_idx,
  input wire logic [127:0] st_data,
  // Load issue and commit
  input wire logic ld_valid,
  input wire logic [31:0] ld_addr,
  input wire logic [2:0] ld_size,
  input wire logic [4:0] ld_sb_pos,
  input wire logic [7:0] ld_pc,
  input wire logic [3:0] ld_tag,
  input wire logic ld_commit,
  input wire logic [3:0] ld_commit_tag,
  input wire logic [7:0] ld_commit_pc,
  output logic ld_fwd_valid,
  output logic [127:0] ld_fwd_data,
  output logic ld_fwd_block,
  output logic ld_wait,
  output logic ld_spec,
  output logic replay_valid,
  output logic [3:0] replay_tag,
  // Write-back miss handling
  input wire logic mreq_valid,
  input wire logic mreq_store,
  input wire logic [31:0] mreq_addr,
  input wire logic [1:0] own_state,
  input wire logic victim_dirty,
  output logic mreq_ready,
  output logic xq_req,
  output logic [31:0] xq_addr,
  input wire logic xq_resp_valid,
  input wire logic xq_other_mod,
  input wire logic xq_l2_hit,
  input wire logic [511:0] xq_data,
  output logic mem_req,
  input wire logic mem_done,
  input wire logic [511:0] mem_data,
  output logic evict_valid,
  output logic l1d_wr_valid,
  output logic l1d_wr_line,
  output logic l1d_wr_store,
  output logic [1:0] l1d_wr_state,
  output logic [511:0] l1d_wr_data,
  output logic mreq_done,
  output logic [1:0] mreq_src
);
  localparam int PF_N = UP_N + DN_N;
  localparam int PFW = $clog2(PF_N);
  localparam int SBW = $clog2(SB_N);
  localparam int LQW = $clog2(LQ_N);
  localparam int PIW = $clog2(PRED_N);
  // Remote modified hit: core cycles plus 5.5 bus cycles
  localparam int OTHER_LAT = cmc_pkg::OTHER_CORE_CYC
    + (cmc_pkg::OTHER_BUS_HALVES * BUS_RATIO + 1) / 2;

  // Position of a store buffer slot counted from the head
  function automatic logic [SBW-1:0] sb_age(input logic [SBW-1:0] i, input logic [SBW-1:0] h);
    logic [SBW:0] t;
    t = (i >= h) ? {1'h0, i - h} : {1'h0, i} + (SBW+1)'(SB_N) - {1'h0, h};
    return t[SBW-1:0];
  endfunction

  // One stride step up or down, with page overflow visible
  function automatic logic [7:0] step(input logic [7:0] p, input logic [5:0] m, input logic dn);
    return dn ? p - {2'h0, m} : p + {2'h0, m};
  endfunction

  // Prefetch tracking arrays, ascending slots first
  logic pf_vld [PF_N];
  logic [19:0] pf_page [PF_N];
  logic [5:0] pf_last [PF_N]; // Last line touched
  logic [5:0] pf_mag [PF_N]; // Stride in lines
  logic pf_conf [PF_N]; // Stream seen twice
  logic [7:0] pf_next [PF_N]; // Next line to prefetch
  logic [PFW-1:0] up_ptr; // Ascending victim
  logic [PFW-1:0] dn_ptr; // Descending victim, relative

  logic own; // Request belongs to this core
  logic hit;
  logic [PFW-1:0] hidx;
  logic [5:0] cur;
  logic [6:0] d; // Signed line delta
  logic dn; // Stream goes downward
  logic [5:0] mag;
  logic in_dn; // Hit entry sits in descending array
  logic moving;
  logic cont;
  logic [PFW-1:0] slot;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] dist0;
  logic [7:0] dist1;
  logic [7:0] lim;
  logic ok0;
  logic ok1;

  // Stream lookup and prefetch candidates
  always_comb begin
    own = dreq_valid && dreq_core == CORE_ID;
    cur = dreq_addr[11:6];
    hit = 1'h0;
    hidx = '0;
    for (int e = 0; e < PF_N; e++) begin
      if (pf_vld[e] && pf_page[e] == dreq_addr[31:12]) begin
        hit = 1'h1;
        hidx = PFW'(e);
      end
    end
    d = {1'h0, cur} - {1'h0, pf_last[hidx]};
    dn = d[6];
    mag = dn ? 6'(-d) : d[5:0]; // Any stride, skips included
    in_dn = 32'(hidx) >= UP_N;
    moving = own && hit && d != 7'h00;
    cont = moving && pf_conf[hidx] && dn == in_dn && mag == pf_mag[hidx];
    // New page goes to ascending; direction change moves arrays
    if (!hit || (dn != in_dn && !dn)) begin
      slot = up_ptr;
    end else if (dn != in_dn) begin
      slot = PFW'(UP_N) + dn_ptr;
    end else begin
      slot = hidx;
    end
    // Resume where the stream left off if still ahead
    if (cont && (dn ? pf_next[hidx] < {2'h0, cur} : pf_next[hidx] > {2'h0, cur})) begin
      c0 = pf_next[hidx];
    end else begin
      c0 = step({2'h0, cur}, mag, dn);
    end
    c1 = step(c0, mag, dn);
    dist0 = dn ? {2'h0, cur} - c0 : c0 - {2'h0, cur};
    dist1 = dn ? {2'h0, cur} - c1 : c1 - {2'h0, cur};
    // Halve reach per busy condition: 8, 4 or 2 lines
    lim = 8'(cmc_pkg::PF_MAX_AHEAD) >> ({1'h0, bus_busy}
      + {1'h0, outst_cnt >= 4'(cmc_pkg::OUTST_HIGH)});
    ok0 = moving && c0[7:6] == 2'h0 && dist0 <= lim;
    ok1 = ok0 && c1[7:6] == 2'h0 && dist1 <= lim;
  end

  // Tracking entry updates
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < PF_N; e++) begin
        pf_vld[e] <= 1'h0;
        pf_page[e] <= 20'h0_0000;
        pf_last[e] <= 6'h00;
        pf_mag[e] <= 6'h00;
        pf_conf[e] <= 1'h0;
        pf_next[e] <= 8'h00;
      end
      up_ptr <= '0;
      dn_ptr <= '0;
    end else if (own && (!hit || moving)) begin
      // Allocate or rewrite the chosen slot
      pf_vld[slot] <= 1'h1;
      pf_page[slot] <= dreq_addr[31:12];
      pf_last[slot] <= cur;
      pf_mag[slot] <= hit ? mag : 6'h00;
      pf_conf[slot] <= hit;
      pf_next[slot] <= ok1 ? step(c1, mag, dn) : (ok0 ? c1 : c0);
      if (hit && dn != in_dn) begin
        pf_vld[hidx] <= 1'h0; // Entry changed direction
      end
      // A miss leaves hidx at zero, so a miss always advances
      if (slot == up_ptr && (!hit || slot != hidx)) begin
        up_ptr <= (32'(up_ptr) == UP_N - 1) ? '0 : up_ptr + 1'h1;
      end
      if (hit && dn && !in_dn) begin
        dn_ptr <= (32'(dn_ptr) == DN_N - 1) ? '0 : dn_ptr + 1'h1;
      end
    end
  end

  // Prefetch request outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pf_valid <= 2'h0;
      pf_addr0 <= 32'h0000_0000;
      pf_addr1 <= 32'h0000_0000;
    end else begin
      pf_valid <= {ok1, ok0};
      pf_addr0 <= {dreq_addr[31:12], c0[5:0], 6'h00};
      pf_addr1 <= {dreq_addr[31:12], c1[5:0], 6'h00};
    end
  end

  // Store buffer contents
  logic sb_vld [SB_N];
  logic sb_aok [SB_N]; // Address known
  logic sb_dok [SB_N]; // Data known
  logic [31:0] sb_addr [SB_N];
  logic [2:0] sb_size [SB_N];
  logic [127:0] sb_data [SB_N];
  logic [SBW-1:0] sb_head;
  logic [SBW-1:0] sb_tail;
  logic sb_ovl [SB_N];
  logic sb_fok [SB_N];

  // One checker per store slot against the issuing load
  for (genvar g = 0; g < SB_N; g++) begin : g_sb
    cmc_fwd_check u_chk (
      .st_addr(sb_addr[g]),
      .st_size(sb_size[g]),
      .ld_addr(ld_addr),
      .ld_size(ld_size),
      .overlap(sb_ovl[g]),
      .fwd_ok(sb_fok[g])
    );
  end

  // Store buffer allocate, fill and retire
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SB_N; i++) begin
        sb_vld[i] <= 1'h0;
        sb_aok[i] <= 1'h0;
        sb_dok[i] <= 1'h0;
        sb_addr[i] <= 32'h0000_0000;
        sb_size[i] <= 3'h0;
        sb_data[i] <= '0;
      end
      sb_head <= '0;
      sb_tail <= '0;
    end else begin
      if (st_retire) begin
        sb_vld[sb_head] <= 1'h0;
        sb_head <= (32'(sb_head) == SB_N - 1) ? '0 : sb_head + 1'h1;
      end
      if (st_alloc) begin
        sb_vld[sb_tail] <= 1'h1;
        sb_aok[sb_tail] <= 1'h0;
        sb_dok[sb_tail] <= 1'h0;
        sb_tail <= (32'(sb_tail) == SB_N - 1) ? '0 : sb_tail + 1'h1;
      end
      if (st_addr_valid) begin
        sb_aok[st_idx] <= 1'h1;
        sb_addr[st_idx] <= st_addr;
        sb_size[st_idx] <= st_size;
      end
      if (st_data_valid) begin
        sb_dok[st_data_idx] <= 1'h1;
        sb_data[st_data_idx] <= st_data;
      end
    end
  end

  logic [SBW-1:0] ld_older; // Stores older than the load
  logic best_hit;
  logic [SBW-1:0] best_age;
  logic [SBW-1:0] best_idx;
  logic any_unknown; // Older store address unresolved
  logic [6:0] shamt;

  // Youngest older overlapping store wins
  always_comb begin
    ld_older = sb_age(ld_sb_pos, sb_head);
    best_hit = 1'h0;
    best_age = '0;
    best_idx = '0;
    any_unknown = 1'h0;
    for (int i = 0; i < SB_N; i++) begin
      if (sb_vld[i] && sb_age(SBW'(i), sb_head) < ld_older) begin
        if (!sb_aok[i]) begin
          any_unknown = 1'h1;
        end else if (sb_ovl[i] && (!best_hit || sb_age(SBW'(i), sb_head) >= best_age)) begin
          best_hit = 1'h1;
          best_age = sb_age(SBW'(i), sb_head);
          best_idx = SBW'(i);
        end
      end
    end
    shamt = {ld_addr[3:0] - sb_addr[best_idx][3:0], 3'h0};
  end

  // Disambiguation predictor and speculative load tracker
  logic [cmc_pkg::PRED_W-1:0] pred [PRED_N];
  logic lq_vld [LQ_N];
  logic [31:0] lq_addr [LQ_N];
  logic [2:0] lq_size [LQ_N];
  logic [SBW-1:0] lq_pos [LQ_N];
  logic [PIW-1:0] lq_pi [LQ_N];
  logic [3:0] lq_tag [LQ_N];
  logic lq_ovl [LQ_N];
  logic lq_hit [LQ_N]; // Conflict on this entry
  logic safe;
  logic lq_free;
  logic [LQW-1:0] free_idx;
  logic conflict;
  logic [LQW-1:0] cf_idx;

  // Later store addresses are checked against tracked loads
  for (genvar g = 0; g < LQ_N; g++) begin : g_lq
    cmc_fwd_check u_chk (
      .st_addr(st_addr),
      .st_size(st_size),
      .ld_addr(lq_addr[g]),
      .ld_size(lq_size[g]),
      .overlap(lq_ovl[g]),
      .fwd_ok()
    );
  end

  // Prediction lookup, free slot and conflict search
  always_comb begin
    safe = &pred[ld_pc[PIW-1:0]];
    lq_free = 1'h0;
    free_idx = '0;
    conflict = 1'h0;
    cf_idx = '0;
    for (int j = LQ_N - 1; j >= 0; j--) begin
      lq_hit[j] = st_addr_valid && lq_vld[j] && lq_ovl[j]
        && sb_age(st_idx, sb_head) < sb_age(lq_pos[j], sb_head);
      if (!lq_vld[j]) begin
        lq_free = 1'h1;
        free_idx = LQW'(j);
      end
      if (lq_hit[j]) begin
        conflict = 1'h1;
        cf_idx = LQW'(j);
      end
    end
  end

  logic go_spec;
  assign go_spec = ld_valid && any_unknown && safe && lq_free;

  // Tracker entries live from speculative issue to commit or a conflict
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int j = 0; j < LQ_N; j++) begin
        lq_vld[j] <= 1'h0;
        lq_addr[j] <= 32'h0000_0000;
        lq_size[j] <= 3'h0;
        lq_pos[j] <= '0;
        lq_pi[j] <= '0;
        lq_tag[j] <= 4'h0;
      end
    end else begin
      for (int j = 0; j < LQ_N; j++) begin
        if (lq_hit[j] || (ld_commit && lq_tag[j] == ld_commit_tag)) begin
          lq_vld[j] <= 1'h0;
        end
      end
      if (go_spec) begin
        lq_vld[free_idx] <= 1'h1;
        lq_addr[free_idx] <= ld_addr;
        lq_size[free_idx] <= ld_size;
        lq_pos[free_idx] <= ld_sb_pos;
        lq_pi[free_idx] <= ld_pc[PIW-1:0];
        lq_tag[free_idx] <= ld_tag;
      end
    end
  end

  // Counters learn on commit, collapse on a conflict
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < PRED_N; p++) begin
        pred[p] <= '0;
      end
    end else begin
      if (ld_commit && !(&pred[ld_commit_pc[PIW-1:0]])) begin
        pred[ld_commit_pc[PIW-1:0]] <= pred[ld_commit_pc[PIW-1:0]] + 1'h1;
      end
      if (conflict) begin
        pred[lq_pi[cf_idx]] <= '0;
      end
    end
  end

  // Load answer and replay outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ld_fwd_valid <= 1'h0;
      ld_fwd_block <= 1'h0;
      ld_fwd_data <= '0;
      ld_wait <= 1'h0;
      ld_spec <= 1'h0;
      replay_valid <= 1'h0;
      replay_tag <= 4'h0;
    end else begin
      // A full tracker cannot cover the gamble, so wait
      ld_wait <= ld_valid && any_unknown && !(safe && lq_free);
      ld_spec <= go_spec;
      ld_fwd_valid <= ld_valid && (!any_unknown || go_spec) && best_hit
        && sb_fok[best_idx] && sb_dok[best_idx];
      ld_fwd_block <= ld_valid && (!any_unknown || go_spec) && best_hit
        && !(sb_fok[best_idx] && sb_dok[best_idx]);
      ld_fwd_data <= sb_data[best_idx] >> shamt;
      replay_valid <= conflict;
      replay_tag <= lq_tag[cf_idx];
    end
  end

  // Write-back miss handler
  cmc_pkg::cmc_miss_e mstate;
  logic m_store;
  logic [7:0] lat_cnt;
  assign mreq_ready = mstate == cmc_pkg::M_IDLE;

  // Lookup order: own cache, other core with L2, memory
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mstate <= cmc_pkg::M_IDLE;
      m_store <= 1'h0;
      lat_cnt <= 8'h00;
      xq_req <= 1'h0;
      xq_addr <= 32'h0000_0000;
      mem_req <= 1'h0;
      evict_valid <= 1'h0;
      l1d_wr_valid <= 1'h0;
      l1d_wr_line <= 1'h0;
      l1d_wr_store <= 1'h0;
      l1d_wr_state <= cmc_pkg::ST_I;
      l1d_wr_data <= '0;
      mreq_done <= 1'h0;
      mreq_src <= cmc_pkg::SRC_OWN;
    end else begin
      xq_req <= 1'h0;
      mem_req <= 1'h0;
      evict_valid <= 1'h0;
      l1d_wr_valid <= 1'h0;
      mreq_done <= 1'h0;
      case (mstate)
        cmc_pkg::M_IDLE: begin
          if (mreq_valid) begin
            m_store <= mreq_store;
            xq_addr <= {mreq_addr[31:6], 6'h00};
            if (!mreq_store && own_state != cmc_pkg::ST_I) begin
              mreq_done <= 1'h1; // Own cache hit
              mreq_src <= cmc_pkg::SRC_OWN;
            end else if (mreq_store && own_state >= cmc_pkg::ST_E) begin
              l1d_wr_valid <= 1'h1; // Owned already
              l1d_wr_line <= 1'h0;
              l1d_wr_store <= 1'h1;
              l1d_wr_state <= cmc_pkg::ST_M;
              mreq_done <= 1'h1;
              mreq_src <= cmc_pkg::SRC_OWN;
            end else begin
              xq_req <= 1'h1; // Other core and L2 together
              evict_valid <= victim_dirty && own_state == cmc_pkg::ST_I;
              mstate <= cmc_pkg::M_PROBE;
            end
          end
        end
        cmc_pkg::M_PROBE: begin
          if (xq_resp_valid) begin
            l1d_wr_data <= xq_data;
            if (xq_other_mod) begin
              // Modified copy wins whatever the L2 holds
              lat_cnt <= 8'(OTHER_LAT - 1);
              mreq_src <= cmc_pkg::SRC_OTHER;
              mstate <= cmc_pkg::M_OTHER;
            end else if (xq_l2_hit) begin
              mreq_src <= cmc_pkg::SRC_L2;
              mstate <= cmc_pkg::M_FILL;
            end else begin
              mem_req <= 1'h1;
              mreq_src <= cmc_pkg::SRC_MEM;
              mstate <= cmc_pkg::M_MEM;
            end
          end
        end
        cmc_pkg::M_OTHER: begin
          // Remote transfer takes its full latency
          if (lat_cnt == 8'h00) begin
            mstate <= cmc_pkg::M_FILL;
          end else begin
            lat_cnt <= lat_cnt - 8'h01;
          end
        end
        cmc_pkg::M_MEM: begin
          if (mem_done) begin
            l1d_wr_data <= mem_data;
            mstate <= cmc_pkg::M_FILL;
          end
        end
        cmc_pkg::M_FILL: begin
          // Stores merge their data and become Modified
          l1d_wr_valid <= 1'h1;
          l1d_wr_line <= 1'h1;
          l1d_wr_store <= m_store;
          if (m_store) begin
            l1d_wr_state <= cmc_pkg::ST_M;
          end else if (mreq_src == cmc_pkg::SRC_OTHER) begin
            l1d_wr_state <= cmc_pkg::ST_S;
          end else begin
            l1d_wr_state <= cmc_pkg::ST_E;
          end
          mreq_done <= 1'h1;
          mstate <= cmc_pkg::M_IDLE;
        end
        default: begin
          mstate <= cmc_pkg::M_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/cmc_pkg.sv ***
// Constants shared by the core memory cluster files.
// Assumes byte addresses, 64-byte lines and 4K pages.
package cmc_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_OFS = 6; // Line offset bits
  localparam int PAGE_OFS = 12; // Page offset bits
  localparam int LINE_BITS = 512; // One cache line
  localparam int PF_UP_N = 12; // Ascending tracking entries
  localparam int PF_DN_N = 4; // Descending tracking entries
  localparam int PF_PER_LOOKUP = 2; // Prefetches per lookup
  localparam int PF_MAX_AHEAD = 8; // Lines ahead, idle bus
  localparam int OUTST_HIGH = 4; // Outstanding count deemed busy
  localparam int SB_N = 20; // Store buffer entries
  localparam int LQ_N = 4; // Speculative loads tracked
  localparam int PRED_N = 16; // Disambiguation predictor entries
  localparam int PRED_W = 2; // Predictor counter width
  localparam int TAG_W = 4; // Load tag width
  localparam int OTHER_CORE_CYC = 14; // Core cycles, remote hit
  localparam int OTHER_BUS_HALVES = 11; // 5.5 bus cycles in halves
  localparam int BUS_RATIO = 4; // Core cycles per bus cycle
  // Access sizes, log2 of bytes
  localparam logic [2:0] SZ_4 = 3'h2;
  localparam logic [2:0] SZ_8 = 3'h3;
  localparam logic [2:0] SZ_16 = 3'h4;
  // Line states
  localparam logic [1:0] ST_I = 2'h0;
  localparam logic [1:0] ST_S = 2'h1;
  localparam logic [1:0] ST_E = 2'h2;
  localparam logic [1:0] ST_M = 2'h3;
  // Miss handler states
  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_PROBE = 5'h02,
    M_OTHER = 5'h04,
    M_MEM = 5'h08,
    M_FILL = 5'h10
  } cmc_miss_e;
  // Where a request was served from
  typedef enum logic [1:0] {
    SRC_OWN = 2'h0,
    SRC_OTHER = 2'h1,
    SRC_L2 = 2'h2,
    SRC_MEM = 2'h3
  } cmc_src_e;
endpackage

// *** rtl/cmc_fwd_check.sv ***
// Overlap and forwarding test of one store against one load.
// Pure logic; sizes are log2 of the byte count.
`timescale 1ns/1ps
`default_nettype none
module cmc_fwd_check (
  input wire logic [31:0] st_addr,
  input wire logic [2:0] st_size,
  input wire logic [31:0] ld_addr,
  input wire logic [2:0] ld_size,
  output logic overlap,
  output logic fwd_ok
);
  logic [32:0] st_end; // One past last store byte
  logic [32:0] ld_end; // One past last load byte
  logic [4:0] ld_bytes; // Load length
  logic line_x; // Load crosses a line
  logic q_x; // Load crosses 8 bytes
  logic start_ok; // Start address acceptable

  // Whole check is combinational
  always_comb begin
    st_end = {1'h0, st_addr} + (33'h1 << st_size);
    ld_end = {1'h0, ld_addr} + (33'h1 << ld_size);
    overlap = ({1'h0, ld_addr} < st_end) && ({1'h0, st_addr} < ld_end);
    ld_bytes = 5'h01 << ld_size;
    line_x = ({1'h0, ld_addr[5:0]} + {2'h0, ld_bytes}) > 7'h40;
    q_x = ({2'h0, ld_addr[2:0]} + ld_bytes) > 5'h08
      && ld_size != cmc_pkg::SZ_16;
    // Same start, or an aligned half/quarter of a wide store
    start_ok = (ld_addr == st_addr)
      || (st_size == cmc_pkg::SZ_8 && st_addr[2:0] == 3'h0 && ld_size == cmc_pkg::SZ_4
          && ld_addr[31:3] == st_addr[31:3] && ld_addr[1:0] == 2'h0)
      || (st_size == cmc_pkg::SZ_16 && st_addr[3:0] == 4'h0 && ld_addr[31:4] == st_addr[31:4]
          && ((ld_size == cmc_pkg::SZ_4 && ld_addr[1:0] == 2'h0)
          || (ld_size == cmc_pkg::SZ_8 && ld_addr[2:0] == 3'h0)));
    fwd_ok = overlap && ld_size <= st_size && !line_x && !q_x && start_ok;
  end
endmodule
`default_nettype wire

// *** tb/cmc_cluster_chk.sv ***
// Port checker of cmc_cluster, bound into every instance.
// Assumes CORE_ID 0 and BUS_RATIO 4.
`timescale 1ns/1ps
`default_nettype none
module cmc_cluster_chk (
  input wire logic ref_clk, resetn, dreq_valid, dreq_core, ld_valid, ld_fwd_valid, ld_fwd_block,
  input wire logic ld_wait, ld_spec, xq_req, evict_valid, xq_resp_valid, xq_l2_hit, xq_other_mod,
  input wire logic mreq_done, l1d_wr_valid, l1d_wr_store,
  input wire logic [1:0] pf_valid, mreq_src, l1d_wr_state,
  input wire logic [31:0] dreq_addr, pf_addr0
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  pf_pair_a: assert property (pf_valid[1] |-> pf_valid[0]) else $error("pair");
  pf_cause_a: assert property (|pf_valid |-> $past(dreq_valid & !dreq_core)) else $error("cause");
  pf_page_a: assert property (pf_valid[0] |-> pf_addr0[31:12] == $past(dreq_addr[31:12]))
    else $error("page");
  ld_one_a: assert property ($onehot0({ld_fwd_valid, ld_fwd_block, ld_wait, ld_spec})) else $error("one");
  ld_spec_a: assert property (ld_spec |-> $past(ld_valid)) else $error("spec");
  evict_par_a: assert property (evict_valid |-> xq_req) else $error("evict");
  l2_fill_a: assert property (xq_resp_valid & xq_l2_hit & !xq_other_mod |-> ##2 l1d_wr_valid && mreq_src == 2'h2)
    else $error("l2");
  other_fill_a: assert property (xq_resp_valid & xq_other_mod |-> ##38 mreq_done && mreq_src == 2'h1)
    else $error("other");
  st_mod_a: assert property (l1d_wr_valid & l1d_wr_store |-> l1d_wr_state == 2'h3) else $error("mod");
  cover property (pf_valid == 2'h3);
  cover property (ld_fwd_valid);
  cover property (evict_valid);
endmodule
bind cmc_cluster cmc_cluster_chk chk_u (.*);
`default_nettype wire

// *** tb/cmc_far_model.sv ***
// Far side model: other core with shared L2, and memory.
// Answers two cycles after each request; mode picks the outcome.
`timescale 1ns/1ps
`default_nettype none
module cmc_far_model (
  input wire logic ref_clk, xq_req, mem_req,
  input wire logic [1:0] mode, // 0 miss, 1 L2 hit, 2 modified in other core
  output logic xq_resp_valid, xq_other_mod, xq_l2_hit, mem_done,
  output logic [511:0] xq_data, mem_data
);
  logic [3:0] sh = '0; // Delay pipes of both requests
  always @(posedge ref_clk) sh <= {sh[2], mem_req, sh[0], xq_req};
  assign xq_resp_valid = sh[1];
  assign mem_done = sh[3];
  assign xq_other_mod = sh[1] & mode[1];
  assign xq_l2_hit = sh[1] & |mode; // L2 holds it too, yet the modified copy must win
  // Inverted outside the valid cycle, so stale data never matches
  assign xq_data = {16{sh[1] ? 32'h5A5A_0001 : 32'hA5A5_FFFE}};
  assign mem_data = {16{sh[3] ? 32'h0F0F_0002 : 32'hF0F0_FFFD}};
endmodule
`default_nettype wire

// *** tb/tb_cmc_cluster.sv ***
// Self-checking bench of cmc_cluster with the far side model.
// Inputs change on falling edges; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module tb_cmc_cluster;
  int n_fail = 0, checks = 0;
  logic ref_clk = '0, resetn = '0, dreq_valid = '0, dreq_core = '0, bus_busy = '0, st_alloc = '0, st_retire = '0;
  logic st_addr_valid = '0, st_data_valid = '0, ld_valid = '0, ld_commit = '0, mreq_valid = '0, mreq_store = '0;
  logic victim_dirty = '0;
  logic [31:0] dreq_addr = '0, st_addr = '0, ld_addr = '0, mreq_addr = 32'h0000_8000;
  logic [4:0] st_idx = '0, st_data_idx = '0, ld_sb_pos = '0;
  logic [3:0] outst_cnt = '0, ld_tag = '0, ld_commit_tag = '0;
  logic [2:0] st_size = 3'h3, ld_size = '0;
  logic [7:0] ld_pc = '0, ld_commit_pc = '0;
  logic [1:0] own_state = '0, mode = '0;
  logic [127:0] st_data = '0;
  wire logic ld_fwd_valid, ld_fwd_block, ld_wait, ld_spec, replay_valid, mreq_ready, xq_req, mem_req, mreq_done;
  wire logic xq_resp_valid, xq_other_mod, xq_l2_hit, mem_done, evict_valid, l1d_wr_valid, l1d_wr_line, l1d_wr_store;
  wire logic [1:0] pf_valid, l1d_wr_state, mreq_src;
  wire logic [3:0] replay_tag;
  wire logic [31:0] pf_addr0, pf_addr1, xq_addr;
  wire logic [127:0] ld_fwd_data;
  wire logic [511:0] xq_data, mem_data, l1d_wr_data;
  cmc_cluster dut_u (.*);
  cmc_far_model far_u (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  // Request by line number; prefetch answer judged one cycle on
  task automatic dq(input logic c, input logic [25:0] a, input logic [1:0] v, input logic [25:0] e0, e1);
    dreq_valid = 1'h1; dreq_core = c; dreq_addr = {a, 6'h0};
    @(negedge ref_clk);
    `CK(pf_valid, v)
    if (v[0]) `CK(pf_addr0, {e0, 6'h0})
    if (v[1]) `CK(pf_addr1, {e1, 6'h0})
  endtask
  // Load issue, flags one cycle on, then an idle cycle
  task automatic ld(input logic [11:0] a, input logic [31:0] ed, input logic [2:0] z, input logic [4:0] p, e);
    ld_valid = 1'h1; ld_addr = {20'h0, a}; ld_size = z; ld_sb_pos = p;
    @(negedge ref_clk);
    `CK({ld_fwd_valid, ld_fwd_block, ld_wait, ld_spec}, e[3:0])
    if (e[3]) `CK(ld_fwd_data[31:0], ed)
    ld_valid = 1'h0;
    @(negedge ref_clk);
  endtask
  // Miss request; waits for completion, then source and state
  task automatic mr(input logic s, dt, input logic [1:0] o, m, src, stt);
    int n;
    mode = m; mreq_valid = 1'h1; mreq_store = s; own_state = o; victim_dirty = dt;
    `CK(mreq_ready, 1'h1)
    @(negedge ref_clk);
    mreq_valid = 1'h0;
    for (n = 0; n < 60 && mreq_done !== 1'h1; n++) @(negedge ref_clk);
    `CK({mreq_done, mreq_src}, {1'h1, src})
    if (src != 2'h0) `CK({l1d_wr_state, l1d_wr_store}, {stt, s})
    if (src != 2'h0) `CK({l1d_wr_line, xq_addr}, {1'h1, mreq_addr})
    if (src != 2'h0) `CK(l1d_wr_data[31:0], src == 2'h3 ? 32'h0F0F_0002 : 32'h5A5A_0001)
    @(negedge ref_clk);
  endtask
  // Streams up, busy bus, other core, down, skipping, page end
  task automatic t_pf;
    dq(0, 26'h40, 0, 0, 0);
    dq(0, 26'h41, 3, 26'h42, 26'h43);
    bus_busy = 1'h1; outst_cnt = 4'h4;
    dq(0, 26'h42, 1, 26'h44, 0);
    bus_busy = 1'h0; outst_cnt = 4'h0;
    dq(1, 26'h43, 0, 0, 0);
    dq(0, 26'hA0, 0, 0, 0);
    dq(0, 26'h9F, 3, 26'h9E, 26'h9D);
    dq(0, 26'hC0, 0, 0, 0);
    dq(0, 26'hC2, 3, 26'hC4, 26'hC6);
    dq(0, 26'h13D, 0, 0, 0);
    dq(0, 26'h13E, 1, 26'h13F, 0);
    dq(0, 26'hC4, 3, 26'hC8, 26'hCA);
    dreq_valid = 1'h0;
  endtask
  // Two stores to one place; youngest older wins, limits refuse
  task automatic t_fwd;
    for (int i = 0; i < 2; i++) begin
      st_alloc = 1'h1;
      @(negedge ref_clk);
      st_alloc = 1'h0; st_addr_valid = 1'h1; st_data_valid = 1'h1; st_addr = 32'h0000_0100;
      st_idx = i[4:0]; st_data_idx = i[4:0]; st_data = {64'h0, 32'h1111_0000 + i[31:0], 32'h0};
      @(negedge ref_clk);
      st_addr_valid = 1'h0; st_data_valid = 1'h0;
    end
    ld(12'h104, 32'h1111_0001, 3'h2, 5'h2, 5'h8);
    ld(12'h104, 32'h1111_0000, 3'h2, 5'h1, 5'h8);
    ld(12'h100, 0, 3'h4, 5'h2, 5'h4);
    ld(12'h102, 0, 3'h2, 5'h2, 5'h4);
    ld(12'h106, 0, 3'h2, 5'h2, 5'h4);
  endtask
  // Unknown older store: wait, learn, speculate, then replay
  task automatic t_dis;
    st_alloc = 1'h1; ld_pc = 8'h05; ld_tag = 4'h9;
    @(negedge ref_clk);
    st_alloc = 1'h0;
    ld(12'h200, 0, 3'h2, 5'h3, 5'h2);
    ld_commit = 1'h1; ld_commit_pc = 8'h05; ld_commit_tag = 4'h9;
    repeat (3) @(negedge ref_clk);
    ld_commit = 1'h0;
    ld(12'h200, 0, 3'h2, 5'h3, 5'h1);
    st_addr_valid = 1'h1; st_idx = 5'h02; st_addr = 32'h0000_0200;
    @(negedge ref_clk);
    st_addr_valid = 1'h0;
    `CK({replay_valid, replay_tag}, 5'h19)
  endtask
  task automatic close_out;
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog; the tests need some 115 cycles
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'h1;
    @(negedge ref_clk);
    t_pf();
    t_fwd();
    t_dis();
    mr(0, 0, 2'h1, 2'h1, 2'h0, 2'h0);
    mr(1, 0, 2'h2, 2'h1, 2'h0, 2'h0);
    mr(0, 1, 2'h0, 2'h1, 2'h2, 2'h2);
    mr(0, 0, 2'h0, 2'h2, 2'h1, 2'h1);
    mr(0, 0, 2'h0, 2'h0, 2'h3, 2'h2);
    mr(1, 0, 2'h1, 2'h1, 2'h2, 2'h3);
    close_out();
  end
endmodule
`undef CK
`default_nettype wire
